// [logic/tps_defines.vh]
// register map, field layout and reset values for the timer divider block
`ifndef TPS_DEFINES_VH
`define TPS_DEFINES_VH

`define TPS_OFF_CTRL0    12'h000
`define TPS_OFF_CTRL1    12'h004
`define TPS_OFF_CNT_LO   12'h008
`define TPS_OFF_CNT_HI   12'h00c
`define TPS_OFF_PERIOD   12'h010
`define TPS_OFF_IRQ_REQ  12'h014
`define TPS_OFF_IRQ_EN   12'h018
`define TPS_OFF_INTCTL   12'h01c

// first control register fields
`define TPS_C0_EN        7
`define TPS_C0_OUT       5
`define TPS_C0_MODE16    4
`define TPS_C0_PS_HI     3
`define TPS_C0_PS_LO     0
// second control register fields
`define TPS_C1_ASYNC     4
`define TPS_C1_PR_HI     3
`define TPS_C1_PR_LO     0
// irq request / enable bit position
`define TPS_IRQ_BIT      5
// interrupt control: global peripheral enable
`define TPS_IC_PERIPHERAL_GLOBAL_IRQ_ENABLE      6

`define TPS_RST_BYTE     8'h00
`define TPS_RST_PERIOD   8'hff
`define TPS_CNT_MAX      16'hffff
`define TPS_WR_MASK_C0   8'h9f
`define TPS_WR_MASK_C1   8'h1f
`define TPS_IE_MASK      8'h37
`define TPS_IC_MASK      8'h40

`endif

// [logic/tps_timer.v]
// timer prescaler, counter, postscaler, output and interrupt with apb regs
// ====================================================================
// Functional notes
// RL1 - sixteen power-of-two input divisions, 1:1 to 1:32768, four-bit select
// RL2 - prescaler count is never readable or directly writable
// RL3 - prescaler clears on counter low, control writes, and reset
// RL4 - postscaler offers 1:1 to 1:16 via four-bit field in control zero
// RL5 - postscaler count is neither readable nor loadable
// RL6 - postscaler clears on counter low, control writes, and reset
// RL7 - synchronous clocking stops counting during sleep
// RL8 - async clocking counts in sleep; enabled event raises wake
// RL9 - enable bit five of enable register zero gates timer interrupt
// RL10 - register-zero interrupts ignore the global peripheral enable
// RL11 - event: low byte equals period (8-bit) or wrap from max (16-bit)
// RL12 - flag sets every postscale plus one events
// RL13 - output toggles on each postscaled event, 50% duty
// RL14 - select n divides the timer clock by two to the n
// RL15 - new divider selections start from a cleared count
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "tps_defines.vh"

module tps_timer #(
  parameter PS_W = 15,
  parameter POST_W = 4
) (
  input wire i_core_clk, // system clock, 250 MHz
  input wire i_nrst, // synchronous reset, active low
  input wire i_ce, // clock enable, freezes state when low
  input wire i_tmr_clk_pin, // selected timer input clock from pin
  input wire i_sleep, // processor sleep request, same domain
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire i_pwrite, // apb direction
  input wire [11:0] i_paddr, // apb byte address
  input wire [31:0] i_pwdata, // apb write data
  output reg [31:0] o_prdata, // apb read data
  output reg o_pready, // apb ready
  output reg o_pslverr, // apb error, unmapped address
  output reg o_tmr_out, // postscaled square wave output
  output reg o_irq, // interrupt to processor
  output reg o_wake // wake request while asleep
);

  // ==================================================================
  // register state
  reg [7:0] ctrl0_q;
  reg [7:0] ctrl1_q;
  reg [7:0] cnt_lo_q;
  reg [7:0] cnt_hi_q;
  reg [7:0] period_q;
  reg [7:0] irq_req_q;
  reg [7:0] irq_en_q;
  reg [7:0] intctl_q;
  reg [PS_W-1:0] ps_cnt_q;
  reg [POST_W-1:0] post_cnt_q;
  reg pin_s1_q;
  reg pin_s2_q;
  reg pin_s3_q;

  function [3:0] dec_reg;
    input [11:0] a;
    begin
      case (a)
        `TPS_OFF_CTRL0: dec_reg = 4'h0;
        `TPS_OFF_CTRL1: dec_reg = 4'h1;
        `TPS_OFF_CNT_LO: dec_reg = 4'h2;
        `TPS_OFF_CNT_HI: dec_reg = 4'h3;
        `TPS_OFF_PERIOD: dec_reg = 4'h4;
        `TPS_OFF_IRQ_REQ: dec_reg = 4'h5;
        `TPS_OFF_IRQ_EN: dec_reg = 4'h6;
        `TPS_OFF_INTCTL: dec_reg = 4'h7;
        default: dec_reg = 4'hf;
      endcase
    end
  endfunction

  // ==================================================================
  // apb access decode
  wire acc = i_psel & i_penable & o_pready;
  wire [3:0] sel = dec_reg(i_paddr);
  wire wr = acc & i_pwrite;
  wire wr_c0 = wr & (sel == 4'h0);
  wire wr_c1 = wr & (sel == 4'h1);
  wire wr_lo = wr & (sel == 4'h2);
  wire wr_hi = wr & (sel == 4'h3);
  wire wr_pr = wr & (sel == 4'h4);
  wire wr_rq = wr & (sel == 4'h5);
  wire wr_ie = wr & (sel == 4'h6);
  wire wr_ic = wr & (sel == 4'h7);
  // divider clear: also gives a full first period after a new selection
  wire div_clr = wr_c0 | wr_c1 | wr_lo; // RL3 RL6 RL15

  // ==================================================================
  // timer clock source and sleep gating
  wire async_mode = ctrl1_q[`TPS_C1_ASYNC];
  wire pin_rise = pin_s2_q & ~pin_s3_q;
  // sync mode halts in sleep; async source keeps running
  wire run = ctrl0_q[`TPS_C0_EN] & (async_mode | ~i_sleep); // RL7 RL8
  wire tick_in = run & pin_rise;

  wire [3:0] ps_sel = ctrl1_q[`TPS_C1_PR_HI:`TPS_C1_PR_LO];
  wire [PS_W:0] ps_next = {1'b0, ps_cnt_q} + {{PS_W{1'b0}}, 1'b1};
  // select n: tick when the low n bits wrap, divide by 2^n
  wire ps_tick = tick_in &
    ((ps_sel == 4'h0) | ps_next[ps_sel]); // RL1 RL14

  wire mode16 = ctrl0_q[`TPS_C0_MODE16];
  wire [15:0] cnt16 = {cnt_hi_q, cnt_lo_q};
  wire match8 = ps_tick & ~mode16 & (cnt_lo_q == period_q); // RL11
  wire wrap16 = ps_tick & mode16 & (cnt16 == `TPS_CNT_MAX); // RL11
  wire tmr_evt = match8 | wrap16;

  wire [3:0] post_sel = ctrl0_q[`TPS_C0_PS_HI:`TPS_C0_PS_LO]; // RL4
  wire post_evt = tmr_evt & (post_cnt_q == post_sel); // RL12

  // set wins over write-one-to-clear
  wire [7:0] req_d = (irq_req_q & ~(wr_rq ? i_pwdata[7:0] : 8'h00)) |
    ({7'h00, post_evt} << `TPS_IRQ_BIT);
  // enable gates only; global peripheral enable not consulted
  wire irq_d = irq_req_q[`TPS_IRQ_BIT] & irq_en_q[`TPS_IRQ_BIT]; // RL9 RL10

  // ==================================================================
  // synchroniser for the timer input pin
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else if (i_ce) begin
      pin_s1_q <= i_tmr_clk_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ==================================================================
  // dividers: internal only, no bus path reads or loads them
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ps_cnt_q <= {PS_W{1'b0}}; // RL3
      post_cnt_q <= {POST_W{1'b0}}; // RL6
    end else if (i_ce) begin
      if (div_clr) begin
        ps_cnt_q <= {PS_W{1'b0}}; // RL2 RL3
        post_cnt_q <= {POST_W{1'b0}}; // RL5 RL6
      end else begin
        if (tick_in)
          ps_cnt_q <= ps_tick ? {PS_W{1'b0}} : ps_next[PS_W-1:0];
        if (post_evt)
          post_cnt_q <= {POST_W{1'b0}};
        else if (tmr_evt)
          post_cnt_q <= post_cnt_q + {{(POST_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ==================================================================
  // counter, registers and outputs
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ctrl0_q <= `TPS_RST_BYTE;
      ctrl1_q <= `TPS_RST_BYTE;
      cnt_lo_q <= `TPS_RST_BYTE;
      cnt_hi_q <= `TPS_RST_BYTE;
      period_q <= `TPS_RST_PERIOD;
      irq_req_q <= `TPS_RST_BYTE;
      irq_en_q <= `TPS_RST_BYTE;
      intctl_q <= `TPS_RST_BYTE;
      o_tmr_out <= 1'b0;
      o_irq <= 1'b0;
      o_wake <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      if (wr_c0)
        ctrl0_q <= i_pwdata[7:0] & `TPS_WR_MASK_C0;
      else if (post_evt)
        ctrl0_q[`TPS_C0_OUT] <= ~ctrl0_q[`TPS_C0_OUT];
      if (wr_c1)
        ctrl1_q <= i_pwdata[7:0] & `TPS_WR_MASK_C1;
      if (wr_pr)
        period_q <= i_pwdata[7:0];
      if (wr_ie)
        irq_en_q <= i_pwdata[7:0] & `TPS_IE_MASK;
      if (wr_ic)
        intctl_q <= i_pwdata[7:0] & `TPS_IC_MASK;
      if (wr_lo)
        cnt_lo_q <= i_pwdata[7:0];
      else if (match8)
        cnt_lo_q <= `TPS_RST_BYTE;
      else if (ps_tick)
        cnt_lo_q <= cnt16[7:0] + 8'h01;
      if (wr_hi)
        cnt_hi_q <= i_pwdata[7:0];
      else if (ps_tick & mode16 & (cnt_lo_q == 8'hff))
        cnt_hi_q <= cnt_hi_q + 8'h01;
      irq_req_q <= req_d;
      if (post_evt)
        o_tmr_out <= ~o_tmr_out; // RL13
      o_irq <= irq_d;
      o_wake <= irq_d & i_sleep & async_mode; // RL8
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & (dec_reg(i_paddr) == 4'hf);
      if (i_psel & ~i_penable & ~i_pwrite) begin
        case (dec_reg(i_paddr))
          4'h0: o_prdata <= {24'h000000, ctrl0_q};
          4'h1: o_prdata <= {24'h000000, ctrl1_q};
          4'h2: o_prdata <= {24'h000000, cnt_lo_q};
          4'h3: o_prdata <= {24'h000000, cnt_hi_q};
          4'h4: o_prdata <= {24'h000000, period_q};
          4'h5: o_prdata <= {24'h000000, irq_req_q};
          4'h6: o_prdata <= {24'h000000, irq_en_q};
          4'h7: o_prdata <= {24'h000000, intctl_q};
          default: o_prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// [verif/tps_timer_bench.sv]
// self-checking bench for the timer divider block
`timescale 1ns/1ps
`include "tps_defines.vh"
module tps_timer_bench;
  reg clk = 0, nrst = 0, pin = 0, slp = 0, psel = 0, pen = 0, pwr = 0;
  reg [11:0] pa = 0;
  reg [31:0] pwd = 0, rd;
  wire [31:0] prd;
  wire rdy, err, tout, irq, wake;
  integer fail_count = 0, n_tests = 0, i, seed = 96578;
  reg [7:0] mdl [0:7];
  reg tg = 0, er = 0;
  tps_timer DUT (.i_core_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
    .i_tmr_clk_pin(pin), .i_sleep(slp), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(err), .o_tmr_out(tout), .o_irq(irq),
    .o_wake(wake));
  initial forever #2 clk = ~clk;
  function integer xs(input integer s);
    integer t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // write masks: control zero output bit is read-only
  function [7:0] msk(input [2:0] x);
    case (x)
      0: msk = 8'h9f;
      1: msk = 8'h1f;
      6: msk = 8'h37;
      7: msk = 8'h40;
      default: msk = 8'hff;
    endcase
  endfunction
  task stop_test;
    begin
      $display("tests %0d fails %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // ====================================
  // apb master and register model
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
      @(posedge clk);
      pen <= 1;
      n = 0;
      // look mid-cycle, so ready and data are taken before the closing edge
      @(negedge clk);
      while (rdy !== 1'b1 && n < 20) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 20) begin fail_count = fail_count + 1; stop_test; end
      rd = prd;
      er = err;
      @(posedge clk);
      {psel, pen} <= 2'b00;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      apb(1, a, d);
      mdl[a[4:2]] = d[7:0] & msk(a[4:2]);
    end
  endtask
  task rdc(input [11:0] a);
    begin
      apb(0, a, 0);
      chk(rd, {24'h0, mdl[a[4:2]]});
    end
  endtask
  // pin kept well below a quarter of the core rate
  task pulse(input integer k);
    begin
      repeat (k) begin
        pin <= 1;
        repeat (4) @(posedge clk);
        pin <= 0;
        repeat (4) @(posedge clk);
      end
      repeat (4) @(posedge clk);
    end
  endtask
  // period 2 in 8-bit mode, so one event per three ticks
  task divtest(input [3:0] ps, input [3:0] po);
    integer tot;
    begin
      tot = (1 << ps) * 3 * (po + 1);
      wr(`TPS_OFF_PERIOD, 2);
      // start from a known count so no stray event lands early
      wr(`TPS_OFF_CNT_LO, 0);
      wr(`TPS_OFF_CTRL1, ps);
      wr(`TPS_OFF_CTRL0, 8'h80 | po);
      pulse(tot - 1);
      wr(`TPS_OFF_CNT_LO, 0);
      wr(`TPS_OFF_IRQ_REQ, 8'h20);
      pulse(tot - 1);
      apb(0, `TPS_OFF_IRQ_REQ, 0);
      chk(rd[5], 0);
      pulse(1);
      apb(0, `TPS_OFF_IRQ_REQ, 0);
      chk(rd[5], 1);
      tg = ~tg;
      chk(tout, tg);
      wr(`TPS_OFF_INTCTL, 0);
      wr(`TPS_OFF_IRQ_EN, 8'h20);
      repeat (3) @(posedge clk);
      chk(irq, 1);
      wr(`TPS_OFF_IRQ_EN, 0);
      wr(`TPS_OFF_IRQ_REQ, 8'h20);
      apb(0, `TPS_OFF_IRQ_REQ, 0);
      chk(rd[5], 0);
      $display("divider test %0d %0d done", ps, po);
    end
  endtask
  initial begin
    for (i = 0; i < 8; i = i + 1) mdl[i] = 0;
    mdl[4] = `TPS_RST_PERIOD;
    repeat (2) @(posedge clk);
    nrst <= 1;
    for (i = 0; i < 8; i = i + 1) rdc(i * 4);
    apb(0, 12'h020, 0);
    chk({er, rd}, 33'h100000000);
    for (i = 0; i < 8; i = i + 1) if (i != 5) begin
      seed = xs(seed);
      wr(i * 4, seed);
      rdc(i * 4);
    end
    $display("register test done");
    divtest(0, 0);
    divtest(1, 15);
    divtest(3, 2);
    // ====================================
    // sleep: sync halts, async counts and wakes
    slp <= 1;
    wr(`TPS_OFF_CTRL1, 0);
    wr(`TPS_OFF_CNT_LO, 0);
    pulse(2);
    rdc(`TPS_OFF_CNT_LO);
    wr(`TPS_OFF_CTRL0, 8'h80);
    wr(`TPS_OFF_IRQ_EN, 8'h20);
    wr(`TPS_OFF_CTRL1, 8'h10);
    pulse(1);
    apb(0, `TPS_OFF_CNT_LO, 0);
    chk(rd, 1);
    pulse(2);
    chk(wake, 1);
    slp <= 0;
    $display("sleep test done");
    stop_test;
  end
endmodule

// [verif/tps_timer_checker.sv]
// assertion checker for the timer divider block
`timescale 1ns/1ps
`include "tps_defines.vh"
module tps_timer_checker (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_ce,
  input wire i_tmr_clk_pin,
  input wire i_sleep,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_tmr_out,
  input wire o_irq,
  input wire o_wake
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  wire setup = i_psel && !i_penable;
  wire acc = i_psel && i_penable && o_pready;
  // ====================================
  // bus handshake, one wait-free access
  ready_take_a: assert property (setup |=> o_pready) else $error("no ready");
  ready_cause_a: assert property (o_pready |-> $past(setup))
    else $error("stray ready");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready too long");
  err_addr_a: assert property (setup && i_paddr > 12'h01c |=> o_pslverr)
    else $error("unmapped not refused");
  rdata_hold_a: assert property (!(setup && !i_pwrite) |=> $stable(o_prdata))
    else $error("read data moved");
  // ====================================
  // interrupt, wake and reset
  irq_mask_a: assert property (acc && i_pwrite && !i_pwdata[5] &&
    i_paddr == `TPS_OFF_IRQ_EN |-> ##2 !o_irq) else $error("irq not masked");
  wake_sleep_a: assert property (!i_sleep [*2] |=> !o_wake)
    else $error("wake while awake");
  rst_clear_a: assert property ($rose(i_nrst) |->
    !o_irq && !o_wake && !o_tmr_out && !o_pready) else $error("reset outs");
  cover property (acc && o_pslverr);
  cover property ($rose(o_irq));
  cover property ($rose(o_wake));
endmodule
bind tps_timer tps_timer_checker u_chk (.*);
